//--- rtl/pfs_pkg.sv
// constants, states and carriers of the power-fail supervisor
package pfs_pkg;

  // --------------------------------------------------------------
  // clock and internal oscillator
  // --------------------------------------------------------------
  localparam int CLK_MHZ = 20;
  localparam int OSC_HZ = 32768;

  // --------------------------------------------------------------
  // delays
  // --------------------------------------------------------------
  localparam int PROTECT_DELAY_MIN_US = 40;
  localparam int PROTECT_DELAY_TYP_US = 100;
  localparam int PROTECT_DELAY_MAX_US = 160;
  localparam int PROTECT_TICKS = (PROTECT_DELAY_TYP_US * OSC_HZ + 999_999) / 1_000_000;
  localparam int RECOVERY_MIN_MS = 40;
  localparam int RECOVERY_TYP_MS = 100;
  localparam int RECOVERY_MAX_MS = 200;
  localparam int RECOVERY_TICKS = (RECOVERY_TYP_MS * OSC_HZ + 999) / 1000;
  localparam int CLEAR_HOLD_NS = 50;
  localparam int CLEAR_HOLD_RAW = (CLEAR_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int CLEAR_HOLD_CYCLES = (CLEAR_HOLD_RAW < 1) ? 1 : CLEAR_HOLD_RAW;
  localparam int TIMER_W = 16;
  localparam int HOLD_W = 4;

  // --------------------------------------------------------------
  // bus and register map
  // --------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] FLAGS_ADDR = 15'h7ff0;
  localparam logic [ADDR_W-1:0] IRQ_ADDR = 15'h7ff6;
  localparam int FLAG_SUPPLY_BIT = 4;
  localparam int FLAG_CELL_BIT = 3;
  localparam int IRQ_SUPPLY_EN_BIT = 5;
  localparam logic [DATA_W-1:0] IRQ_RESET = 8'h00;

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_DOWN,
    ST_RECOVER,
    ST_RUN,
    ST_WARN
  } pfs_state_e;

  typedef struct packed {
    logic cs_n;
    logic we_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] din;
    logic supply_fail;
    logic cell_low;
    logic osc_tick;
  } pfs_pins_s;

  typedef struct packed {
    logic deselect;
    logic write_protect;
    logic write_en;
  } pfs_mem_ctl_s;

endpackage

//--- rtl/pfs_power_fail_supervisor.sv
// power-fail supervisor: supply sequencing, flags and host bus rules
//
// Overview of operation
// - supply drop sets the supply fail flag
// - flag and enable pull interrupt low
// - writes allowed for protect delay, then protect
// - irq enable bit cleared at every power-up
// - power-up samples cell, sets cell low flag
// - write protect held for recovery after power-up
// - write only during chip-select and strobe overlap
// - late chip-select keeps data outputs released
// - write with output gate high, pins released
// - interrupt and reset are pull-low only
// - flags read clears event flags, releases interrupt
// - reset low from power-down through recovery
// - irq enable bit lives in interrupts register
`timescale 1ns/1ps
module pfs_power_fail_supervisor #(
  parameter int PROTECT_TICKS = pfs_pkg::PROTECT_TICKS,
  parameter int RECOVERY_TICKS = pfs_pkg::RECOVERY_TICKS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire pfs_pkg::pfs_pins_s pins,
  output logic [pfs_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic irq_n_out,
  output logic irq_n_oe,
  output logic rst_n_out,
  output logic rst_n_oe,
  output pfs_pkg::pfs_mem_ctl_s mem_ctl,
  output logic supply_fail_flag,
  output logic cell_low_flag
);

  localparam int PW = $bits(pfs_pkg::pfs_pins_s);
  localparam logic [pfs_pkg::TIMER_W-1:0] PROT_LIM = PROTECT_TICKS[pfs_pkg::TIMER_W-1:0];
  localparam logic [pfs_pkg::TIMER_W-1:0] REC_LIM = RECOVERY_TICKS[pfs_pkg::TIMER_W-1:0];
  localparam logic [pfs_pkg::HOLD_W-1:0] HOLD_LIM = pfs_pkg::CLEAR_HOLD_CYCLES[pfs_pkg::HOLD_W-1:0];

  // --------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------
  logic [PW-1:0] sync1_q;
  logic [PW-1:0] sync2_q;
  pfs_pkg::pfs_pins_s p;

  // every pin crosses two flops before use
  genvar gi;
  generate
    for (gi = 0; gi < PW; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          sync1_q[gi] <= 1'b1;
          sync2_q[gi] <= 1'b1;
        end else begin
          sync1_q[gi] <= pins[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  assign p = pfs_pkg::pfs_pins_s'(sync2_q);

  // --------------------------------------------------------------
  // edge detection on synchronised levels
  // --------------------------------------------------------------
  logic tick_d_q;
  logic fail_d_q;
  logic cs_n_d_q;
  logic tick_rise;
  logic fail_rise;
  logic cs_fall;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_d_q <= 1'b1;
      fail_d_q <= 1'b1;
      cs_n_d_q <= 1'b1;
    end else begin
      tick_d_q <= p.osc_tick;
      fail_d_q <= p.supply_fail;
      cs_n_d_q <= p.cs_n;
    end
  end

  assign tick_rise = p.osc_tick & ~tick_d_q;
  assign fail_rise = p.supply_fail & ~fail_d_q;
  assign cs_fall = ~p.cs_n & cs_n_d_q;

  // --------------------------------------------------------------
  // power sequencer
  // --------------------------------------------------------------
  pfs_pkg::pfs_state_e state_q;
  pfs_pkg::pfs_state_e state_d;
  logic tmr_start;
  logic tmr_done;
  logic [pfs_pkg::TIMER_W-1:0] tmr_limit;
  logic power_up;
  logic powered;

  assign powered = (state_q == pfs_pkg::ST_RUN) || (state_q == pfs_pkg::ST_WARN);
  assign tmr_limit = powered ? PROT_LIM : REC_LIM;
  assign power_up = (state_q == pfs_pkg::ST_DOWN) && (state_d == pfs_pkg::ST_RECOVER);

  always_comb begin
    state_d = state_q;
    tmr_start = 1'b0;
    case (state_q)
      pfs_pkg::ST_DOWN: begin
        if (!p.supply_fail) begin
          state_d = pfs_pkg::ST_RECOVER;
          tmr_start = 1'b1;
        end
      end
      pfs_pkg::ST_RECOVER: begin
        // a new drop restarts the whole sequence
        if (p.supply_fail) begin
          state_d = pfs_pkg::ST_DOWN;
        end else if (tmr_done) begin
          state_d = pfs_pkg::ST_RUN;
        end
      end
      pfs_pkg::ST_RUN: begin
        if (p.supply_fail) begin
          state_d = pfs_pkg::ST_WARN;
          tmr_start = 1'b1;
        end
      end
      pfs_pkg::ST_WARN: begin
        // no return on a brief recovery: the cut is always completed
        if (tmr_done) begin
          state_d = pfs_pkg::ST_DOWN;
        end
      end
      default: begin
        state_d = pfs_pkg::ST_DOWN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= pfs_pkg::ST_DOWN;
    end else begin
      state_q <= state_d;
    end
  end

  pfs_tick_timer #(
    .W(pfs_pkg::TIMER_W)
  ) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(tmr_start),
    .tick(tick_rise),
    .limit(tmr_limit),
    .done(tmr_done)
  );

  // --------------------------------------------------------------
  // host bus decode
  // --------------------------------------------------------------
  logic sel;
  logic wr_allow;
  logic overlap;
  logic wr_act_q;
  logic commit;
  logic late_cs_q;
  logic late_cs;
  logic [pfs_pkg::ADDR_W-1:0] wa_addr_q;
  logic [pfs_pkg::DATA_W-1:0] wa_data_q;

  // in ST_DOWN no read or write is decoded; only the late-select flag still follows cs_n
  assign sel = ~p.cs_n & (state_q != pfs_pkg::ST_DOWN);
  assign wr_allow = powered;
  assign overlap = sel & ~p.we_n & wr_allow;
  assign commit = wr_act_q & ~overlap & wr_allow;
  assign late_cs = late_cs_q | (cs_fall & ~p.we_n);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_act_q <= 1'b0;
      wa_addr_q <= '0;
      wa_data_q <= '0;
    end else begin
      wr_act_q <= overlap;
      if (overlap) begin
        wa_addr_q <= p.addr;
        wa_data_q <= p.din;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      late_cs_q <= 1'b0;
    end else if (p.cs_n) begin
      late_cs_q <= 1'b0;
    end else if (cs_fall && !p.we_n) begin
      late_cs_q <= 1'b1;
    end
  end

  // --------------------------------------------------------------
  // interrupts register
  // --------------------------------------------------------------
  logic [pfs_pkg::DATA_W-1:0] irq_reg_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_reg_q <= pfs_pkg::IRQ_RESET;
    end else if (power_up) begin
      irq_reg_q[pfs_pkg::IRQ_SUPPLY_EN_BIT] <= 1'b0;
    end else if (commit && wa_addr_q == pfs_pkg::IRQ_ADDR) begin
      irq_reg_q <= wa_data_q;
    end
  end

  // --------------------------------------------------------------
  // flags and read-clear
  // --------------------------------------------------------------
  logic flags_rd;
  logic clear_evt;
  logic [pfs_pkg::HOLD_W-1:0] hold_q;
  logic supply_flag_q;
  logic cell_flag_q;
  logic [pfs_pkg::DATA_W-1:0] flags_byte;

  assign flags_rd = sel & p.we_n & (p.addr == pfs_pkg::FLAGS_ADDR);
  // clear at the end of the read so the data stays valid throughout
  assign clear_evt = ~flags_rd & (hold_q >= HOLD_LIM);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_q <= '0;
    end else if (!flags_rd) begin
      hold_q <= '0;
    end else if (hold_q < HOLD_LIM) begin
      hold_q <= hold_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      supply_flag_q <= 1'b0;
    end else if (fail_rise) begin
      supply_flag_q <= 1'b1;
    end else if (clear_evt) begin
      supply_flag_q <= 1'b0;
    end
  end

  // cell is a status, not an event: only power-up changes it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cell_flag_q <= 1'b0;
    end else if (power_up) begin
      cell_flag_q <= p.cell_low;
    end
  end

  always_comb begin
    flags_byte = '0;
    flags_byte[pfs_pkg::FLAG_SUPPLY_BIT] = supply_flag_q;
    flags_byte[pfs_pkg::FLAG_CELL_BIT] = cell_flag_q;
  end

  // --------------------------------------------------------------
  // data pins
  // --------------------------------------------------------------
  logic [pfs_pkg::DATA_W-1:0] dq_out_q;
  logic dq_oe_q;
  logic reg_hit;

  assign reg_hit = (p.addr == pfs_pkg::FLAGS_ADDR) || (p.addr == pfs_pkg::IRQ_ADDR);

  // strobe low or late select keeps the pins released
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dq_oe_q <= 1'b0;
      dq_out_q <= '0;
    end else begin
      dq_oe_q <= sel & p.we_n & ~p.oe_n & ~late_cs & reg_hit;
      dq_out_q <= (p.addr == pfs_pkg::FLAGS_ADDR) ? flags_byte : irq_reg_q;
    end
  end

  // --------------------------------------------------------------
  // open-drain outputs and memory control
  // --------------------------------------------------------------
  logic irq_oe_q;
  logic rst_oe_q;
  pfs_pkg::pfs_mem_ctl_s mem_ctl_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_oe_q <= 1'b0;
      rst_oe_q <= 1'b1;
      mem_ctl_q <= '{deselect: 1'b1, write_protect: 1'b1, write_en: 1'b0};
    end else begin
      irq_oe_q <= supply_flag_q & irq_reg_q[pfs_pkg::IRQ_SUPPLY_EN_BIT];
      rst_oe_q <= ~powered;
      mem_ctl_q.deselect <= (state_q == pfs_pkg::ST_DOWN);
      mem_ctl_q.write_protect <= ~wr_allow;
      mem_ctl_q.write_en <= overlap;
    end
  end

  // pins only ever pull low; pull-ups sit outside
  assign irq_n_out = 1'b0;
  assign rst_n_out = 1'b0;
  assign irq_n_oe = irq_oe_q;
  assign rst_n_oe = rst_oe_q;
  assign dq_out = dq_out_q;
  assign dq_oe = dq_oe_q;
  assign mem_ctl = mem_ctl_q;
  assign supply_fail_flag = supply_flag_q;
  assign cell_low_flag = cell_flag_q;

endmodule

//--- rtl/pfs_tick_timer.sv
// oscillator tick counter for protect and recovery delays
`timescale 1ns/1ps
module pfs_tick_timer #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  output logic done
);

  logic [W-1:0] count_q;
  logic running_q;
  logic done_q;

  // --------------------------------------------------------------
  // counting
  // --------------------------------------------------------------
  // the first tick may come at once, so the wait lies between limit-1 and limit ticks
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_q <= '0;
      running_q <= 1'b0;
      done_q <= 1'b0;
    end else if (start) begin
      count_q <= '0;
      running_q <= 1'b1;
      done_q <= 1'b0;
    end else if (running_q && tick) begin
      count_q <= count_q + 1'b1;
      if (count_q + 1'b1 == limit) begin
        running_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end

  assign done = done_q;

endmodule

//--- verif/pfs_chk.sv
// assertions on the power-fail supervisor ports
`timescale 1ns/1ps
module pfs_chk #(
  parameter int PROTECT_TICKS = 4,
  parameter int RECOVERY_TICKS = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire pfs_pkg::pfs_pins_s pins,
  input wire logic [pfs_pkg::DATA_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  input wire logic rst_n_out,
  input wire logic rst_n_oe,
  input wire pfs_pkg::pfs_mem_ctl_s mem_ctl,
  input wire logic supply_fail_flag,
  input wire logic cell_low_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic tick_q;
  int rec_q;
  // raw ticks, so one tick of slack covers the input sync lag
  always_ff @(posedge clk) begin
    tick_q <= pins.osc_tick;
    if (sys_rst || pins.supply_fail || !rst_n_oe) begin
      rec_q <= 0;
    end else if (pins.osc_tick && !tick_q) begin
      rec_q <= rec_q + 1;
    end
  end
  sequence late_sel_s;
    $fell(pins.cs_n) && !pins.we_n;
  endsequence
  sequence run_entry_s;
    $fell(rst_n_oe);
  endsequence
  flag_on_fail_a: assert property (
    $rose(pins.supply_fail) && !mem_ctl.deselect |-> ##[1:4] supply_fail_flag) else $error("flag not set");
  irq_cause_a: assert property (irq_n_oe |-> $past(supply_fail_flag))
    else $error("interrupt without flag");
  open_drain_a: assert property (irq_n_out == 1'b0 && rst_n_out == 1'b0)
    else $error("open drain drives high");
  protect_order_a: assert property ($rose(mem_ctl.write_protect) |-> rst_n_oe && mem_ctl.deselect)
    else $error("protect without reset");
  wp_blocks_a: assert property ($past(mem_ctl.write_protect, 2) && mem_ctl.write_protect |-> !mem_ctl.write_en)
    else $error("write while protected");
  write_overlap_a: assert property (mem_ctl.write_en |-> $past(!pins.cs_n && !pins.we_n, 3))
    else $error("write outside overlap");
  write_hiz_a: assert property ($past(!pins.we_n, 3) |-> !dq_oe)
    else $error("data driven in write");
  late_sel_a: assert property (late_sel_s |-> ##3 !dq_oe [*8])
    else $error("late select drives data");
  run_irq_a: assert property (run_entry_s |-> !irq_n_oe)
    else $error("enable survived power-up");
  recovery_len_a: assert property (
    run_entry_s |-> rec_q >= RECOVERY_TICKS - 1 && rec_q <= RECOVERY_TICKS + 1) else $error("recovery length wrong");
endmodule
bind pfs_power_fail_supervisor pfs_chk #(.PROTECT_TICKS(PROTECT_TICKS), .RECOVERY_TICKS(RECOVERY_TICKS)) chk (
  .clk(clk), .sys_rst(sys_rst), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe), .irq_n_out(irq_n_out),
  .irq_n_oe(irq_n_oe), .rst_n_out(rst_n_out), .rst_n_oe(rst_n_oe), .mem_ctl(mem_ctl),
  .supply_fail_flag(supply_fail_flag), .cell_low_flag(cell_low_flag));

//--- verif/pfs_host_model.sv
// host processor model on the asynchronous bus
`timescale 1ns/1ps
module pfs_host_model (
  input wire logic clk,
  input wire logic dq_oe,
  output logic cs_n,
  output logic we_n,
  output logic oe_n,
  output logic [pfs_pkg::ADDR_W-1:0] addr,
  output logic [pfs_pkg::DATA_W-1:0] din
);
  initial begin
    cs_n = 1'b1;
    we_n = 1'b1;
    oe_n = 1'b1;
    addr = pfs_pkg::IRQ_ADDR;
    din = 8'h00;
  end
  // data wanders only while deselected, so stale data never passes as written
  // and a write always carries the byte that was asked for
  always @(posedge clk) begin
    if (cs_n && we_n) begin
      din <= ~din;
    end
  end
  // address steady while strobe low; late puts select after strobe
  task automatic wr(input logic [pfs_pkg::ADDR_W-1:0] a, input logic [pfs_pkg::DATA_W-1:0] d, input logic late);
    @(negedge clk);
    addr = a;
    din = d;
    cs_n = late;
    we_n = !late;
    @(negedge clk);
    cs_n = 1'b0;
    we_n = 1'b0;
    oe_n = !late;
    repeat (4) @(negedge clk);
    we_n = 1'b1;
    repeat (late ? 8 : 1) @(negedge clk);
    cs_n = 1'b1;
    oe_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic rd(input logic [pfs_pkg::ADDR_W-1:0] a);
    int n;
    @(negedge clk);
    addr = a;
    cs_n = 1'b0;
    oe_n = 1'b0;
    n = 0;
    while (dq_oe !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(negedge clk);
    cs_n = 1'b1;
    oe_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
endmodule

//--- verif/tb.sv
// self-checking bench for the power-fail supervisor
`timescale 1ns/1ps
module tb;
  localparam int PT = 4;
  localparam int RT = 8;
  localparam logic [7:0] EB = 8'(1 << pfs_pkg::IRQ_SUPPLY_EN_BIT);
  logic clk;
  logic sys_rst;
  logic supply_fail;
  logic cell_low;
  logic osc_tick;
  logic cs_n;
  logic we_n;
  logic oe_n;
  logic [pfs_pkg::ADDR_W-1:0] addr;
  logic [pfs_pkg::DATA_W-1:0] din;
  logic [pfs_pkg::DATA_W-1:0] dq_out;
  logic [pfs_pkg::DATA_W-1:0] v;
  logic dq_oe;
  logic irq_n_out;
  logic irq_n_oe;
  logic rst_n_out;
  logic rst_n_oe;
  logic irq_n;
  logic rst_n;
  logic oe_seen;
  pfs_pkg::pfs_pins_s pins;
  pfs_pkg::pfs_mem_ctl_s mem_ctl;
  logic supply_fail_flag;
  logic cell_low_flag;
  logic [2:0] lvl;
  logic [31:0] seed;
  logic [7:0] exp_q[$];
  int failures;
  int checks_done;
  int n;
  assign pins = {cs_n, we_n, oe_n, addr, din, supply_fail, cell_low, osc_tick};
  // pull-ups hold both open-drain lines high when released
  assign irq_n = irq_n_oe ? irq_n_out : 1'b1;
  assign rst_n = rst_n_oe ? rst_n_out : 1'b1;
  assign lvl = {supply_fail_flag, mem_ctl.write_protect, rst_n_oe};
  pfs_power_fail_supervisor #(.PROTECT_TICKS(PT), .RECOVERY_TICKS(RT)) dut (
    .clk(clk), .sys_rst(sys_rst), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe), .irq_n_out(irq_n_out),
    .irq_n_oe(irq_n_oe), .rst_n_out(rst_n_out), .rst_n_oe(rst_n_oe), .mem_ctl(mem_ctl),
    .supply_fail_flag(supply_fail_flag), .cell_low_flag(cell_low_flag));
  pfs_host_model host (
    .clk(clk), .dq_oe(dq_oe), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .din(din));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // slow oscillator, eight clocks a tick
  always begin
    repeat (4) @(negedge clk);
    osc_tick = ~osc_tick;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    if (failures == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wait_lvl(input int k, input logic lv, output int c);
    c = 0;
    while (lvl[k] !== lv && c < 400) begin
      @(negedge clk);
      c++;
    end
    if (c >= 400) begin
      failures++;
      close_out();
    end
  endtask
  task automatic rd(input logic [pfs_pkg::ADDR_W-1:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
    // a read that never drove the pins is a timeout
    if (exp_q.size() != 0) begin
      chk("read answer", 8'h00, 8'(exp_q.size()));
      close_out();
    end
  endtask
  always @(negedge clk) begin
    if (dq_oe === 1'b1 && oe_seen !== 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("dq_oe", 8'h00, 8'h01);
      end else begin
        chk("dq_out", exp_q.pop_front(), dq_out);
      end
    end
    oe_seen <= dq_oe;
  end
  initial begin
    sys_rst = 1'b1;
    supply_fail = 1'b1;
    cell_low = 1'b1;
    osc_tick = 1'b0;
    oe_seen = 1'b0;
    failures = 0;
    checks_done = 0;
    seed = 32'h4dba;
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    supply_fail = 1'b0;
    wait_lvl(0, 1'b0, n);
    chk("recovery", 8'(n >= (RT - 1) * 8 && n <= (RT + 2) * 8), 8'h01);
    repeat (2) @(negedge clk);
    chk("reset pin", {7'h00, rst_n}, 8'h01);
    chk("protect", {7'h00, mem_ctl.write_protect}, 8'h00);
    chk("cell flag", {7'h00, cell_low_flag}, 8'h01);
    rd(pfs_pkg::IRQ_ADDR, pfs_pkg::IRQ_RESET);
    rd(pfs_pkg::FLAGS_ADDR, 8'(1 << pfs_pkg::FLAG_CELL_BIT));
    seed = xs(seed);
    v = seed[7:0] | EB;
    host.wr(pfs_pkg::IRQ_ADDR, v, 1'b0);
    rd(pfs_pkg::IRQ_ADDR, v);
    v = v ^ 8'h0f;
    host.wr(pfs_pkg::IRQ_ADDR, v, 1'b1);
    rd(pfs_pkg::IRQ_ADDR, v);
    // supply drop: flag, interrupt, then protection after the delay
    supply_fail = 1'b1;
    cell_low = 1'b0;
    wait_lvl(2, 1'b1, n);
    chk("flag delay", 8'(n <= 4), 8'h01);
    repeat (2) @(negedge clk);
    chk("irq pin", {7'h00, irq_n}, 8'h00);
    wait_lvl(1, 1'b1, n);
    chk("protect delay", 8'(n >= (PT - 1) * 8 - 2 && n <= PT * 8 + 8), 8'h01);
    chk("reset pin", {6'h00, rst_n, mem_ctl.deselect}, 8'h01);
    supply_fail = 1'b0;
    // a write while down or recovering must be refused
    host.wr(pfs_pkg::IRQ_ADDR, ~v, 1'b0);
    wait_lvl(0, 1'b0, n);
    repeat (2) @(negedge clk);
    chk("irq pin", {7'h00, irq_n}, 8'h01);
    chk("flags", {6'h00, supply_fail_flag, cell_low_flag}, 8'h02);
    rd(pfs_pkg::IRQ_ADDR, v & ~EB);
    host.wr(pfs_pkg::IRQ_ADDR, v, 1'b0);
    repeat (2) @(negedge clk);
    chk("irq pin", {7'h00, irq_n}, 8'h00);
    rd(pfs_pkg::FLAGS_ADDR, 8'(1 << pfs_pkg::FLAG_SUPPLY_BIT));
    repeat (3) @(negedge clk);
    chk("cleared", {6'h00, supply_fail_flag, irq_n}, 8'h01);
    chk("pending reads", 8'h00, 8'(exp_q.size()));
    close_out();
  end
endmodule
